// File: design/e1ec_monitor.v
`timescale 1ns/10ps
`include "e1ec_consts.vh"
module e1ec_monitor #(
  parameter BITS_LONG  = `E1EC_BITS_LONG,
  parameter BITS_SHORT = `E1EC_BITS_SHORT
) (
  input  wire       clk,
  input  wire       srst,
  input  wire       line_bit_strobe,
  input  wire       line_pos,
  input  wire       line_neg,
  input  wire       hdb3_sub_word,
  input  wire       period_select_bit,
  input  wire       violation_mode_bit,
  input  wire       receive_hdb3_enable,
  input  wire       loss_of_sync_flag,
  input  wire       crc4_sync_loss,
  input  wire       align_search,
  input  wire       crc_word_error,
  input  wire       align_word_error,
  input  wire       ebit_strobe,
  input  wire       ebit_value,
  input  wire [3:0] crc_frame_num,
  input  wire       tx_bit_strobe,
  input  wire       tx_bit,
  input  wire [4:0] tx_timeslot,
  input  wire       rx_bit_strobe,
  input  wire       rx_bit,
  input  wire [4:0] rx_timeslot,
  input  wire [7:0] addr,
  input  wire       wr_en,
  input  wire       rd_en,
  input  wire [7:0] wr_data,
  output reg  [7:0] rd_data,
  output reg  [7:0] alarm_interrupt_mask,
  output reg  [7:0] timing_interrupt_mask,
  output reg        period_timer_flag
);
  // ----------------------------------------
  // Period timer on receive line bits
  // ----------------------------------------
  reg  [21:0] tick_q;
  wire [21:0] limit = period_select_bit ? BITS_SHORT[21:0] - 22'd1
                                        : BITS_LONG[21:0] - 22'd1;
  wire        snap = line_bit_strobe && (tick_q >= limit);

  always @(posedge clk) begin
    if (srst) begin
      tick_q            <= 22'd0;
      period_timer_flag <= 1'b0;
    end else begin
      period_timer_flag <= snap;
      if (line_bit_strobe)
        tick_q <= snap ? 22'd0 : tick_q + 22'd1;
    end
  end

  // ----------------------------------------
  // Violation detection
  // ----------------------------------------
  reg  last_pol_q;
  reg  last_bpv_pol_q;
  reg  bpv_seen_q;
  wire mark = line_pos ^ line_neg;
  wire bpv  = line_bit_strobe && mark && (line_pos == last_pol_q);
  wire bpv_counted = bpv && !(receive_hdb3_enable && hdb3_sub_word);
  wire cv   = bpv && bpv_seen_q && (line_pos == last_bpv_pol_q);
  wire viol_inc = violation_mode_bit ? cv : bpv_counted;

  always @(posedge clk) begin
    if (srst) begin
      last_pol_q     <= 1'b0;
      last_bpv_pol_q <= 1'b0;
      bpv_seen_q     <= 1'b0;
    end else if (line_bit_strobe && mark) begin
      last_pol_q <= line_pos;
      if (bpv) begin
        last_bpv_pol_q <= line_pos;
        bpv_seen_q     <= 1'b1;
      end
    end
  end

  // ----------------------------------------
  // Counters
  // ----------------------------------------
  wire [15:0] vcnt;
  wire [9:0]  ccnt;
  wire [9:0]  ecnt;
  wire [11:0] acnt;
  wire        fas_crc_loss = loss_of_sync_flag | crc4_sync_loss;
  wire        ebit_zero = ebit_strobe && !ebit_value &&
                          (crc_frame_num == `E1EC_EBIT_FRAME_A ||
                           crc_frame_num == `E1EC_EBIT_FRAME_B);

  e1ec_sat_counter #(.W(16)) u_vcnt (
    .clk(clk), .srst(srst), .inc(viol_inc),
    .hold(1'b0), .snap(snap), .held_q(vcnt));
  e1ec_sat_counter #(.W(10)) u_ccnt (
    .clk(clk), .srst(srst), .inc(crc_word_error),
    .hold(fas_crc_loss), .snap(snap), .held_q(ccnt));
  e1ec_sat_counter #(.W(10)) u_ecnt (
    .clk(clk), .srst(srst), .inc(ebit_zero),
    .hold(fas_crc_loss), .snap(snap), .held_q(ecnt));
  e1ec_sat_counter #(.W(12)) u_acnt (
    .clk(clk), .srst(srst), .inc(align_word_error),
    .hold(loss_of_sync_flag | align_search), .snap(snap),
    .held_q(acnt));

  // ----------------------------------------
  // Channel monitors
  // ----------------------------------------
  reg [7:0] ctrl_four_q;
  reg [7:0] ctrl_five_q;
  reg [7:0] tx_shift_q;
  reg [7:0] rx_shift_q;
  reg [7:0] tx_mon_q;
  reg [7:0] rx_mon_q;
  reg [2:0] tx_cnt_q;
  reg [2:0] rx_cnt_q;
  wire tx_hit = tx_bit_strobe && tx_timeslot == ctrl_four_q[4:0];
  wire rx_hit = rx_bit_strobe && rx_timeslot == ctrl_five_q[4:0];

  always @(posedge clk) begin
    if (srst) begin
      tx_shift_q <= 8'h00;
      rx_shift_q <= 8'h00;
      tx_mon_q   <= 8'h00;
      rx_mon_q   <= 8'h00;
      tx_cnt_q   <= 3'd0;
      rx_cnt_q   <= 3'd0;
    end else begin
      if (tx_hit) begin
        tx_shift_q <= {tx_shift_q[6:0], tx_bit};
        tx_cnt_q   <= tx_cnt_q + 3'd1;
        if (tx_cnt_q == 3'd7)
          tx_mon_q <= {tx_shift_q[6:0], tx_bit};
      end
      if (rx_hit) begin
        rx_shift_q <= {rx_shift_q[6:0], rx_bit};
        rx_cnt_q   <= rx_cnt_q + 3'd1;
        if (rx_cnt_q == 3'd7)
          rx_mon_q <= {rx_shift_q[6:0], rx_bit};
      end
    end
  end

  // ----------------------------------------
  // Register port
  // ----------------------------------------
  always @(posedge clk) begin
    if (srst) begin
      alarm_interrupt_mask  <= `E1EC_MASK_RESET;
      timing_interrupt_mask <= `E1EC_MASK_RESET;
      ctrl_four_q           <= 8'h00;
      ctrl_five_q           <= 8'h00;
    end else if (wr_en) begin
      case (addr)
        `E1EC_ADDR_ALM_MASK:  alarm_interrupt_mask  <= wr_data;
        `E1EC_ADDR_TIM_MASK:  timing_interrupt_mask <= wr_data;
        `E1EC_ADDR_CTRL_FOUR: ctrl_four_q <= {wr_data[7], 2'b00,
                                              wr_data[4:0]};
        `E1EC_ADDR_CTRL_FIVE: ctrl_five_q <= {wr_data[7], 2'b00,
                                              wr_data[4:0]};
        default: ;
      endcase
    end
  end

  always @(posedge clk) begin
    if (srst) begin
      rd_data <= 8'h00;
    end else if (rd_en) begin
      case (addr)
        `E1EC_ADDR_VCNT_HI:   rd_data <= vcnt[15:8];
        `E1EC_ADDR_VCNT_LO:   rd_data <= vcnt[7:0];
        `E1EC_ADDR_CRC_HI:    rd_data <= {acnt[11:6], ccnt[9:8]};
        `E1EC_ADDR_CRC_LO:    rd_data <= ccnt[7:0];
        `E1EC_ADDR_FEB_HI:    rd_data <= {acnt[5:0], ecnt[9:8]};
        `E1EC_ADDR_FEB_LO:    rd_data <= ecnt[7:0];
        `E1EC_ADDR_ALM_MASK:  rd_data <= alarm_interrupt_mask;
        `E1EC_ADDR_TIM_MASK:  rd_data <= timing_interrupt_mask;
        `E1EC_ADDR_CTRL_FOUR: rd_data <= ctrl_four_q;
        `E1EC_ADDR_TX_MON:    rd_data <= tx_mon_q;
        `E1EC_ADDR_CTRL_FIVE: rd_data <= ctrl_five_q;
        `E1EC_ADDR_RX_MON:    rd_data <= rx_mon_q;
        default:              rd_data <= 8'h00;
      endcase
    end
  end
endmodule // e1ec_monitor

// File: design/e1ec_consts.vh
// What this block does
// - Eight alarm mask bits; 0 masks, 1 enables each interrupt.
// - Eight timing mask bits; 0 masks, 1 enables each interrupt.
// - All counters snapshot each period: 1 s, or 62.5 ms when selected.
// - Every error counter saturates at maximum, never wraps.
// - 16-bit violation counter; bipolar when mode 0, code when 1.
// - Bipolar mode counts same-polarity marks; HDB3 words excluded if enabled.
// - Code mode counts successive same-polarity bipolar violations only.
// - Violation counter ignores sync loss; stops at 65,535.
// - 10-bit CRC4 error counter held in FAS/CRC4 sync loss only.
// - 10-bit E-bit counter counts zero E-bits; held on FAS/CRC4 loss.
// - E-bits taken from first bit of frames 13 and 15.
// - 12-bit alignment word error counter held while sync loss high.
// - No alignment errors counted while searching alignment or multiframes.
// - Address 02/04 pack alignment count with CRC and E-bit MSBs.
// - Monitor one transmit and one receive channel, own 5-bit selectors.
// - Selector value equals timeslot, channels 1..32 as 0..31.
// - Period timer flag derived from receive clock, 1 s or 62.5 ms.
// - Transmit monitor bit 7 first transmitted bit, bit 0 last.
`ifndef E1EC_CONSTS_VH
`define E1EC_CONSTS_VH
`define E1EC_ADDR_VCNT_HI   8'h00
`define E1EC_ADDR_VCNT_LO   8'h01
`define E1EC_ADDR_CRC_HI    8'h02
`define E1EC_ADDR_CRC_LO    8'h03
`define E1EC_ADDR_FEB_HI    8'h04
`define E1EC_ADDR_FEB_LO    8'h05
`define E1EC_ADDR_ALM_MASK  8'h16
`define E1EC_ADDR_TIM_MASK  8'h17
`define E1EC_ADDR_CTRL_FOUR 8'hA8
`define E1EC_ADDR_TX_MON    8'hA9
`define E1EC_ADDR_CTRL_FIVE 8'hAA
`define E1EC_ADDR_RX_MON    8'hAB
`define E1EC_MASK_RESET     8'h00
`define E1EC_PERIOD_LONG_MS 1000
`define E1EC_PERIOD_SHORT_US 62500
// Receive line clock of 2.048 MHz: bit counts per period
`define E1EC_LINE_RATE_HZ   2048000
`define E1EC_BITS_LONG      (`E1EC_LINE_RATE_HZ / 1000 * `E1EC_PERIOD_LONG_MS)
`define E1EC_BITS_SHORT     (`E1EC_LINE_RATE_HZ / 1000 * `E1EC_PERIOD_SHORT_US / 1000)
`define E1EC_EBIT_FRAME_A   4'd13
`define E1EC_EBIT_FRAME_B   4'd15
`define E1EC_SEL_MSB        4
`endif

// File: design/e1ec_sat_counter.v
`timescale 1ns/10ps
// Saturating event counter with snapshot restart
module e1ec_sat_counter #(
  parameter W = 10
) (
  input  wire         clk,
  input  wire         srst,
  input  wire         inc,
  input  wire         hold,
  input  wire         snap,
  output reg  [W-1:0] held_q
);
  reg  [W-1:0] live_q;
  wire         step = inc & ~hold;
  wire         full = &live_q;

  always @(posedge clk) begin
    if (srst) begin
      live_q <= {W{1'b0}};
      held_q <= {W{1'b0}};
    end else if (snap) begin
      // Event on boundary cycle goes to new period
      held_q <= live_q;
      live_q <= {{(W-1){1'b0}}, step};
    end else if (step && !full) begin
      live_q <= live_q + {{(W-1){1'b0}}, 1'b1};
    end
  end
endmodule // e1ec_sat_counter

// File: testbench/e1ec_host.sv
`timescale 1ns/10ps
// Host on the parallel port: one request per call
module e1ec_host (
  input  wire       clk,
  input  wire [7:0] rd_data,
  output reg  [7:0] addr    = 8'h00,
  output reg        wr_en   = 1'b0,
  output reg        rd_en   = 1'b0,
  output reg  [7:0] wr_data = 8'h00
);
  task xfer(input w, input [7:0] a, input [7:0] dw, output [7:0] dr);
    begin
      @(negedge clk);
      addr = a;
      wr_data = dw;
      {wr_en, rd_en} = {w, !w};
      @(negedge clk);
      {wr_en, rd_en} = 2'b00;
      dr = rd_data;
    end
  endtask
endmodule // e1ec_host

// File: testbench/e1ec_assertions.sv
`timescale 1ns/10ps
module e1ec_chk (
  input wire       clk,
  input wire       srst,
  input wire       line_bit_strobe,
  input wire       wr_en,
  input wire       rd_en,
  input wire [7:0] addr,
  input wire [7:0] wr_data,
  input wire [7:0] rd_data,
  input wire [7:0] alarm_interrupt_mask,
  input wire [7:0] timing_interrupt_mask,
  input wire       period_timer_flag
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);
  a_alarm_mask_wr: assert property (wr_en && addr == 8'h16 |=>
    alarm_interrupt_mask == $past(wr_data)) else $error("alarm mask lost");
  a_timing_mask_wr: assert property (wr_en && addr == 8'h17 |=>
    timing_interrupt_mask == $past(wr_data)) else $error("timing mask lost");
  a_mask_hold: assert property (!wr_en |=> $stable(alarm_interrupt_mask)
    && $stable(timing_interrupt_mask)) else $error("mask changed");
  a_mask_readback: assert property (rd_en && addr == 8'h16 |=>
    rd_data == $past(alarm_interrupt_mask)) else $error("mask read bad");
  a_read_hold: assert property (!rd_en |=> $stable(rd_data))
    else $error("read data moved");
  a_unmapped_zero: assert property (rd_en && addr == 8'h40 |=>
    rd_data == 8'h00) else $error("unmapped read not zero");
  a_flag_cause: assert property (period_timer_flag |->
    $past(line_bit_strobe)) else $error("flag without line bit");
  a_flag_spacing: assert property (period_timer_flag |=>
    !period_timer_flag [*7]) else $error("flags too close");
endmodule // e1ec_chk
bind e1ec_monitor e1ec_chk u_chk (.*);

// File: testbench/e1ec_monitor_tb_top.sv
`timescale 1ns/10ps
module e1ec_monitor_tb_top;
  reg        clk, srst, line_bit_strobe, line_pos, line_neg, tx_bit;
  reg        crc_word_error, align_word_error, ebit_strobe, tx_bit_strobe;
  reg        period_select_bit, loss_of_sync_flag;
  reg  [3:0] crc_frame_num;
  reg  [4:0] tx_timeslot;
  reg  [7:0] d;
  wire [7:0] addr, wr_data, rd_data, pt = 8'hA6, pr = 8'h3C;
  wire [7:0] alarm_interrupt_mask, timing_interrupt_mask;
  wire       wr_en, rd_en, period_timer_flag;
  wire       crc4_sync_loss = loss_of_sync_flag;
  wire       align_search = loss_of_sync_flag;
  wire       rx_bit_strobe = tx_bit_strobe, rx_bit = tx_bit;
  wire [4:0] rx_timeslot = tx_timeslot;
  reg        hdb3_sub_word, violation_mode_bit, receive_hdb3_enable;
  wire       ebit_value = 1'b0;
  integer    fails = 0, check_count = 0, flags = 0, cyc = 0, i, j;

  e1ec_monitor #(.BITS_LONG(20), .BITS_SHORT(8)) dut (.*);
  e1ec_host host (.*);

  initial begin
    clk = 0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (period_timer_flag === 1'b1) flags <= flags + 1;
    if (cyc == 30000) begin
      fails = fails + 1;
      summarize;
    end
  end
  task chk(input string nm, input [15:0] e, input [15:0] g);
    begin
      check_count = check_count + 1;
      if (g !== e) fails = fails + 1;
      if (g !== e) $display("CHECK FAILED %s exp %h got %h", nm, e, g);
    end
  endtask
  task rd(input [7:0] a, input [7:0] e);
    begin
      host.xfer(1'b0, a, 8'h00, d);
      chk($sformatf("reg %h", a), e, d);
    end
  endtask
  task rdall(input [47:0] ex);
    integer k;
    for (k = 0; k < 6; k = k + 1) rd(k[7:0], ex[8*k+:8]);
  endtask
  task st(input p, input n, input c, input a, input [3:0] f);
    begin
      @(negedge clk);
      {line_bit_strobe, line_pos, line_neg} = {1'b1, p, n};
      {crc_word_error, align_word_error} = {c, a};
      {ebit_strobe, crc_frame_num} = {f != 4'h0, f};
      @(negedge clk);
      {line_bit_strobe, crc_word_error, align_word_error, ebit_strobe} = 4'h0;
    end
  endtask
  task summarize;
    begin
      $display("checks %0d mismatches %0d", check_count, fails);
      if (fails == 0 && check_count > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
    end
  endtask

  initial begin
    srst = 1;
    {line_bit_strobe, line_pos, line_neg, tx_bit, tx_bit_strobe} = 5'h00;
    {crc_word_error, align_word_error, ebit_strobe} = 3'h0;
    {period_select_bit, loss_of_sync_flag, crc_frame_num} = 6'h00;
    tx_timeslot = 5'h00;
    {hdb3_sub_word, violation_mode_bit, receive_hdb3_enable} = 3'b000;
    repeat (4) @(negedge clk);
    srst = 0;
    rd(8'h16, 8'h00);
    rd(8'h17, 8'h00);
    host.xfer(1'b1, 8'h16, 8'h5A, d);
    host.xfer(1'b1, 8'h17, 8'hA5, d);
    host.xfer(1'b1, 8'h01, 8'hFF, d);
    rd(8'h16, 8'h5A);
    rd(8'h17, 8'hA5);
    rd(8'h01, 8'h00);
    rd(8'h40, 8'h00);
    host.xfer(1'b1, 8'hA8, 8'h05, d);
    host.xfer(1'b1, 8'hAA, 8'h0E, d);
    for (i = 7; i >= 0; i = i - 1)
      for (j = 0; j < 32; j = j + 1) begin
        @(negedge clk);
        tx_timeslot = j[4:0];
        tx_bit = (j == 5) ? pt[i] : (j == 14) ? pr[i] : 1'b1;
        tx_bit_strobe = 1'b1;
        @(negedge clk);
        tx_bit_strobe = 1'b0;
      end
    rd(8'hA9, 8'hA6);
    rd(8'hAB, 8'h3C);
    st(1, 0, 1, 1, 13);
    st(1, 0, 1, 1, 15);
    st(1, 0, 1, 1, 14);
    st(1, 0, 0, 1, 0);
    st(0, 0, 0, 1, 0);
    repeat (14) st(0, 0, 0, 0, 0);
    chk("flags", 0, flags);
    st(0, 0, 0, 0, 0);
    @(negedge clk);
    chk("flags", 1, flags);
    rdall(48'h0214_0300_0300);
    period_select_bit = 1;
    loss_of_sync_flag = 1;
    repeat (3) st(0, 1, 1, 1, 13);
    loss_of_sync_flag = 0;
    repeat (5) st(0, 0, 0, 0, 0);
    @(negedge clk);
    chk("flags", 2, flags);
    rdall(48'h0000_0000_0200);
    repeat (4100) begin
      @(negedge clk);
      {crc_word_error, align_word_error} = 2'b11;
      @(negedge clk);
      {crc_word_error, align_word_error} = 2'b00;
    end
    repeat (8) st(0, 0, 0, 0, 0);
    @(negedge clk);
    rdall(48'h00FC_FFFF_0000);
    violation_mode_bit = 1;
    repeat (3) st(1, 0, 0, 0, 0);
    repeat (5) st(0, 0, 0, 0, 0);
    rd(8'h01, 8'h01);
    {violation_mode_bit, receive_hdb3_enable, hdb3_sub_word} = 3'b011;
    repeat (3) st(1, 0, 0, 0, 0);
    repeat (5) st(0, 0, 0, 0, 0);
    rd(8'h01, 8'h00);
    summarize;
  end
endmodule // e1ec_monitor_tb_top
